// ### rtl/frg_pkg.sv
package frg_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [15:0] FRG_ADDR_MODE_CTRL = 16'hff80;
   localparam logic [15:0] FRG_ADDR_ERASE_SEL1 = 16'hff82;
   localparam logic [15:0] FRG_ADDR_ERASE_SEL2 = 16'hff83;
   // ----------------------------------------
   // reset and read values
   // ----------------------------------------
   localparam logic [7:0] FRG_MODE_CTRL_RST = 8'h80;
   localparam logic [7:0] FRG_ERASE_SEL_RST = 8'h00;
   localparam logic [7:0] FRG_RESERVED_READ = 8'hff;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int FRG_HV_FLAG_BIT = 7;
   // ----------------------------------------
   // writer mode blank area
   // ----------------------------------------
   localparam logic [16:0] FRG_WR_BLANK_LO = 17'h08000;
   localparam logic [16:0] FRG_WR_BLANK_HI = 17'h1ffff;
   // ----------------------------------------
   // operating modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      FRG_MODE_ILLEGAL = 2'h0,
      FRG_MODE_EXPANDED = 2'h1,
      FRG_MODE_EXP_ROM = 2'h2,
      FRG_MODE_SINGLE = 2'h3
   } frg_mode_t;
endpackage

// ### rtl/frg_gate.sv
`timescale 1ns/100ps
module frg_gate (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins
   input wire logic hv_compare_in,
   input wire logic hardware_standby_pin_n,
   input wire logic [1:0] mode_pins,
   input wire logic writer_mode,
   // cpu bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   // writer port
   input wire logic [16:0] writer_addr,
   input wire logic [7:0] writer_array_data,
   // results
   output logic [7:0] cpu_rdata,
   output logic cpu_hit,
   output logic cpu_ext_access,
   output logic [7:0] writer_rdata,
   output logic hw_standby,
   output logic high_voltage_detect_flag,
   output logic [7:0] flash_mode_control,
   output logic [7:0] erase_block_select_1,
   output logic [7:0] erase_block_select_2
);
   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [1:0] hv_sync_r, hv_sync_nxt;
   logic [1:0] hardware_standby_pin_sync_r, hardware_standby_pin_sync_nxt;
   logic [1:0] md_s1_r, md_s1_nxt, md_s2_r, md_s2_nxt;
   logic [1:0] wm_sync_r, wm_sync_nxt;
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt, esel1_r, esel1_nxt, esel2_r, esel2_nxt;
   logic [7:0] rdata_r, rdata_nxt, wrdata_r, wrdata_nxt;
   logic hit_r, hit_nxt, ext_r, ext_nxt, hardware_standby_pin_r, hardware_standby_pin_nxt;
   logic hv;
   logic is_reg;
   logic reg_space;
   logic reserved;
   frg_pkg::frg_mode_t mode;

   always_comb begin
      hv_sync_nxt = {hv_sync_r[0], hv_compare_in};
      hardware_standby_pin_sync_nxt = {hardware_standby_pin_sync_r[0], hardware_standby_pin_n};
      md_s1_nxt = mode_pins;
      md_s2_nxt = md_s1_r;
      wm_sync_nxt = {wm_sync_r[0], writer_mode};
   end

   // ----------------------------------------
   // input decode
   // ----------------------------------------
   // flag from comparator
   assign hv = hv_sync_r[1];
   assign mode = frg_pkg::frg_mode_t'(md_s2_r);
   assign is_reg = (cpu_addr == frg_pkg::FRG_ADDR_MODE_CTRL) ||
      (cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL1) ||
      (cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL2);

   // ----------------------------------------
   // mode and voltage decode
   // ----------------------------------------
   always_comb begin
      reg_space = 1'b0;
      reserved = 1'b0;
      ext_nxt = 1'b0;
      unique case (mode)
         frg_pkg::FRG_MODE_EXPANDED: begin
            reserved = is_reg && hv;
            ext_nxt = is_reg && !hv && (cpu_rd || cpu_wr);
         end
         frg_pkg::FRG_MODE_EXP_ROM: begin
            reg_space = is_reg && hv;
            ext_nxt = is_reg && !hv && (cpu_rd || cpu_wr);
         end
         frg_pkg::FRG_MODE_SINGLE: begin
            reg_space = is_reg && hv;
            reserved = is_reg && !hv;
         end
         frg_pkg::FRG_MODE_ILLEGAL: begin
            reg_space = 1'b0;
         end
      endcase
      hardware_standby_pin_nxt = !hardware_standby_pin_sync_r[1];
      hit_nxt = (reg_space || reserved) && cpu_rd && !hardware_standby_pin_nxt;
      if (hardware_standby_pin_nxt) begin
         ext_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // control register next values
   // ----------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      esel1_nxt = esel1_r;
      esel2_nxt = esel2_r;
      rdata_nxt = frg_pkg::FRG_RESERVED_READ;
      if (reg_space && cpu_wr && !hardware_standby_pin_nxt) begin
         if (cpu_addr == frg_pkg::FRG_ADDR_MODE_CTRL) begin
            ctrl_nxt = cpu_wdata;
         end
         if (cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL1) begin
            esel1_nxt = cpu_wdata;
         end
         if (cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL2) begin
            esel2_nxt = cpu_wdata;
         end
      end
      if (hardware_standby_pin_nxt) begin
         ctrl_nxt = frg_pkg::FRG_MODE_CTRL_RST;
         esel1_nxt = frg_pkg::FRG_ERASE_SEL_RST;
         esel2_nxt = frg_pkg::FRG_ERASE_SEL_RST;
      end
      ctrl_nxt[frg_pkg::FRG_HV_FLAG_BIT] = hv;
      if (reg_space) begin
         if (cpu_addr == frg_pkg::FRG_ADDR_MODE_CTRL) begin
            rdata_nxt = ctrl_r;
         end else if (cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL1) begin
            rdata_nxt = esel1_r;
         end else begin
            rdata_nxt = esel2_r;
         end
      end
   end

   // ----------------------------------------
   // writer read path
   // ----------------------------------------
   always_comb begin
      if (wm_sync_r[1] && writer_addr >= frg_pkg::FRG_WR_BLANK_LO &&
         writer_addr <= frg_pkg::FRG_WR_BLANK_HI) begin
         wrdata_nxt = frg_pkg::FRG_RESERVED_READ;
      end else begin
         wrdata_nxt = writer_array_data;
      end
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hv_sync_r <= 2'h0;
         hardware_standby_pin_sync_r <= 2'h3;
         md_s1_r <= 2'h0;
         md_s2_r <= 2'h0;
         wm_sync_r <= 2'h0;
         ctrl_r <= frg_pkg::FRG_MODE_CTRL_RST;
         esel1_r <= frg_pkg::FRG_ERASE_SEL_RST;
         esel2_r <= frg_pkg::FRG_ERASE_SEL_RST;
         rdata_r <= frg_pkg::FRG_RESERVED_READ;
         wrdata_r <= frg_pkg::FRG_RESERVED_READ;
         hit_r <= 1'b0;
         ext_r <= 1'b0;
         hardware_standby_pin_r <= 1'b0;
      end else begin
         hv_sync_r <= hv_sync_nxt;
         hardware_standby_pin_sync_r <= hardware_standby_pin_sync_nxt;
         md_s1_r <= md_s1_nxt;
         md_s2_r <= md_s2_nxt;
         wm_sync_r <= wm_sync_nxt;
         ctrl_r <= ctrl_nxt;
         esel1_r <= esel1_nxt;
         esel2_r <= esel2_nxt;
         rdata_r <= rdata_nxt;
         wrdata_r <= wrdata_nxt;
         hit_r <= hit_nxt;
         ext_r <= ext_nxt;
         hardware_standby_pin_r <= hardware_standby_pin_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign cpu_rdata = rdata_r;
   assign cpu_hit = hit_r;
   assign cpu_ext_access = ext_r;
   assign writer_rdata = wrdata_r;
   assign hw_standby = hardware_standby_pin_r;
   assign high_voltage_detect_flag = ctrl_r[frg_pkg::FRG_HV_FLAG_BIT];
   assign flash_mode_control = ctrl_r;
   assign erase_block_select_1 = esel1_r;
   assign erase_block_select_2 = esel2_r;
endmodule // frg_gate

// ### test/frg_supply_model.sv
`timescale 1ns/100ps
module frg_supply_model #(
   parameter int SETTLE = 8,
   parameter int HOLD = 10
) (
   // clock and request
   input wire logic sys_clk,
   input wire logic hv_req,
   // supply pins
   output logic rst,
   output logic hv_compare_in,
   // status
   output logic busy
);
   initial begin
      rst = 1'b1;
      busy = 1'b1;
      hv_compare_in = 1'b0;
      repeat (SETTLE) @(posedge sys_clk);
      #1 rst = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (hv_req !== hv_compare_in) begin
            #1 rst = 1'b1;
            busy = 1'b1;
            repeat (HOLD) @(posedge sys_clk);
            #1 hv_compare_in = hv_req;
            repeat (HOLD) @(posedge sys_clk);
            #1 rst = 1'b0;
            busy = 1'b0;
         end
      end
   end
endmodule // frg_supply_model

// ### test/frg_gate_checker.sv
`timescale 1ns/100ps
module frg_gate_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins
   input wire logic hv_compare_in,
   input wire logic hardware_standby_pin_n,
   input wire logic [1:0] mode_pins,
   input wire logic writer_mode,
   // cpu bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   // writer port
   input wire logic [16:0] writer_addr,
   // results
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_hit,
   input wire logic cpu_ext_access,
   input wire logic [7:0] writer_rdata,
   input wire logic hw_standby,
   input wire logic high_voltage_detect_flag,
   input wire logic [7:0] flash_mode_control,
   input wire logic [7:0] erase_block_select_1,
   input wire logic [7:0] erase_block_select_2
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic on = hardware_standby_pin_n;
   wire logic hv = high_voltage_detect_flag & on;
   wire logic ca = cpu_addr == frg_pkg::FRG_ADDR_MODE_CTRL;
   property p_ctrl_rd; cpu_rd && ca && mode_pins[1] && hv
      |=> cpu_hit && cpu_rdata == $past(flash_mode_control); endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
   property p_ext; (cpu_rd || cpu_wr) && ca && on && !hv && mode_pins inside {2'h1, 2'h2}
      |=> cpu_ext_access && !cpu_hit; endproperty
   a_ext: assert property (p_ext) else $error("no external access");
   property p_m3_ff; cpu_rd && ca && on && !hv && mode_pins == 2'h3
      |=> cpu_hit && !cpu_ext_access && cpu_rdata == 8'hff; endproperty
   a_m3_ff: assert property (p_m3_ff) else $error("mode 3 reserved read");
   property p_no_wr; !hv && on && cpu_wr |=> $stable(erase_block_select_1); endproperty
   a_no_wr: assert property (p_no_wr) else $error("write not ignored");
   property p_hv_wr; hv && mode_pins[1] && cpu_wr && cpu_addr == frg_pkg::FRG_ADDR_ERASE_SEL2
      |=> erase_block_select_2 == $past(cpu_wdata); endproperty
   a_hv_wr: assert property (p_hv_wr) else $error("write not taken");
   property p_flag; (hv_compare_in && on)[*5] |-> high_voltage_detect_flag; endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_hardware_standby_pin; (!on)[*4] |-> hw_standby; endproperty
   a_hardware_standby_pin: assert property (p_hardware_standby_pin) else $error("standby missed");
   property p_blank; writer_mode[*4] ##0 writer_addr >= frg_pkg::FRG_WR_BLANK_LO
      |=> writer_rdata == 8'hff; endproperty
   a_blank: assert property (p_blank) else $error("blank area not ff");
endmodule // frg_gate_checker

// ### test/frg_gate_tb_top.sv
`timescale 1ns/100ps
module frg_gate_tb_top;
   logic sys_clk = 1'b0, hv_req = 1'b0, hardware_standby_pin_n = 1'b1, writer_mode = 1'b0;
   logic cpu_rd = 1'b0, cpu_wr = 1'b0, rst, hv_compare_in, busy, cpu_hit, cpu_ext_access;
   logic hw_standby, high_voltage_detect_flag;
   logic [1:0] mode_pins = 2'h3;
   logic [15:0] cpu_addr = 16'h0000;
   logic [16:0] writer_addr = 17'h00000;
   logic [7:0] cpu_wdata = 8'h00, writer_array_data = 8'h00, cpu_rdata, writer_rdata;
   logic [7:0] flash_mode_control, erase_block_select_1, erase_block_select_2, shd [3];
   int errors = 0, num_checks = 0, cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   frg_supply_model sup_u (.*);
   frg_gate dut_u (.*);
   function automatic logic [9:0] exp_rd(input logic [1:0] m, input logic h, input logic [7:0] v);
      if (m == 2'h0) return 10'h0ff;
      if (h && m[1]) return {2'b10, v};
      return (h || m == 2'h3) ? 10'h2ff : 10'h1ff;
   endfunction
   task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic acc(input logic w, input int i, input logic [7:0] d);
      cpu_addr = frg_pkg::FRG_ADDR_MODE_CTRL + 16'(i + (i > 0));
      cpu_rd = !w;
      cpu_wr = w;
      cpu_wdata = d;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic env(input logic [1:0] m, input logic h);
      cpu_rd = 1'b0;
      cpu_wr = 1'b0;
      mode_pins = m;
      if (h !== hv_req) shd = '{8'h80, 8'h00, 8'h00};
      hv_req = h;
      repeat (3) @(posedge sys_clk);
      for (int t = 0; t < 99 && busy; t++) @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      int i;
      logic [7:0] d;
      void'($urandom(94));
      wait (!busy);
      for (int k = 0; k < 8; k++) begin
         env(k[1:0], !k[2]);
         for (int n = 0; n < 16; n++) begin
            i = $urandom % 3;
            d = 8'($urandom);
            if ($urandom % 2) begin
               acc(1'b1, i, d);
               if (!k[2] && k[1]) shd[i] = (i == 0) ? {1'b1, d[6:0]} : d;
               chk("wr", {cpu_hit, cpu_ext_access}, {1'b0, k[2] && (k[1] ^ k[0])});
            end else begin
               acc(1'b0, i, 8'h00);
               chk("rd", {cpu_hit, cpu_ext_access, cpu_rdata}, exp_rd(k[1:0], !k[2], shd[i]));
            end
         end
      end
      chk("regs", {high_voltage_detect_flag, erase_block_select_1}, {1'b0, shd[1]});
      env(2'h3, 1'b1);
      acc(1'b1, 1, 8'h5a);
      chk("sel", erase_block_select_1, 8'h5a);
      chk("ctrl", flash_mode_control, 8'h80);
      hardware_standby_pin_n = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      chk("hardware_standby_pin", {hw_standby, erase_block_select_1, erase_block_select_2}, 17'h10000);
      hardware_standby_pin_n = 1'b1;
      writer_mode = 1'b1;
      for (int n = 0; n < 12; n++) begin
         writer_addr = (n < 2) ? 17'h07fff + 17'(n) : 17'($urandom);
         writer_array_data = 8'($urandom);
         repeat (4) @(posedge sys_clk);
         #1;
         chk("wrd", writer_rdata, (writer_addr >= 17'h08000) ? 8'hff : writer_array_data);
      end
      writer_mode = 1'b0;
      writer_addr = 17'h1ffff;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("wrd", writer_rdata, writer_array_data);
      print_verdict();
   end
endmodule // frg_gate_tb_top
bind frg_gate frg_gate_checker chk_u (.*);
